/* rtl/err_status_cfg.svh */
// Constants for the processor error status block: bit positions and timing counts.
// Assumes inclusion by bare name from the package and the design module.
`ifndef ERR_STATUS_CFG_SVH
`define ERR_STATUS_CFG_SVH
`define STAT_W 4
`define PC_MISSING 3
`define PC_HIPRI 2
`define PC_PORTINT 1
`define PC_LOCKOUT 0
`define ME_TIMEOUT 3
`define ME_BOUNDS 2
`define ME_LOGCHG 1
`define ME_CPU_UE 0
`define PE_DBLHIT 3
`define PE_KEYPAR 2
`define PE_MPAR 1
`define PE_TAPE 0
`define CLEAR_COLUMN 4'h6
`define MEM_TIMEOUT_NS 2000
`define CLK_PERIOD_NS 40
`define MEM_TIMEOUT_CYC ((`MEM_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define KEY_W 8
`define LOG_SEV_NONE 2'h0
`define LOG_SEV_SBE 2'h1
`define LOG_SEV_NCPU 2'h2
`define LOG_SEV_CPU 2'h3
`endif

/* rtl/err_status_pkg.sv */
// Types for the processor error status block.
// Assumes the constants header is on the include path.
`include "err_status_cfg.svh"
package err_status_pkg;
    // One error report offered to the error log
    typedef struct packed {
        logic [3:0] board;
        logic [1:0] chip_row;
        logic [5:0] syndrome;
        logic is_write;
        logic sbe;
        logic ncpu_ue;
        logic cpu_ue;
    } mem_err_rpt_t;
    // Stored error-log entry
    typedef struct packed {
        logic [3:0] board;
        logic [1:0] chip_row;
        logic [5:0] syndrome;
        logic is_write;
        logic multiple;
        logic sbe;
        logic ncpu_ue;
        logic cpu_ue;
    } err_log_t;
    // Cache key store entry
    typedef struct packed {
        logic [7:0] key;
        logic valid;
        logic parity;
    } key_entry_t;
    // Memory micro watchdog states
    typedef enum logic [1:0] {
        WD_IDLE = 2'b01,
        WD_BUSY = 2'b10
    } wd_state_t;
endpackage : err_status_pkg

/* rtl/processor_error_status_regs.sv */
// Error and condition status registers of the processor: port conditions,
// memory error status, processor error status, halt decision and lamp.
// Assumes all inputs are synchronous to clk and event inputs are single-cycle pulses.
//
// Summary of operation
// RL1 - Port condition group mirrors port interface lines
// RL2 - Direct connect: bits 2..0 false, bit3 strapped
// RL3 - Memory status clears on start or panel load
// RL4 - Memory micro time-out sets bit3, halts
// RL5 - Beyond memory size sets bit2, returns zeros
// RL6 - Out-of-bounds during fetch halts processor
// RL7 - Error log change sets bit1; read empties
// RL8 - Log keeps first error unless higher priority
// RL9 - Log entry: board, row, syndrome, flags
// RL10 - CPU uncorrectable sets bit0; fetch halts
// RL11 - Memory status movable; sets summary flag
// RL12 - Processor status clears on start or load
// RL13 - Double hit merges data, sets bit3, halts in fetch if enabled
// RL14 - Odd key parity check sets bit2
// RL15 - Cleared key entry: zero, valid, parity zero
// RL16 - Key parity in fetch halts if enabled
// RL17 - Micro parity sets bit1 and halts, suppressible
// RL18 - Cassette error sets bit0; halts in tape
// RL19 - Lamp lit by error events, not loads
// RL20 - Lamp off on start or panel load
// RL21 - Interrupt from missing device or port interrupt
// RL22 - Status bits stay set until cleared
`timescale 1ns/10ps
`include "err_status_cfg.svh"
module processor_error_status_regs
    import err_status_pkg::*;
#(
    parameter int TIMEOUT_CYC = `MEM_TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    // Port interchange
    input wire logic port_present,
    input wire logic port_missing,
    input wire logic port_hipri,
    input wire logic port_int,
    input wire logic port_lockout,
    input wire logic strap_missing,
    input wire logic other_int,
    // Machine state and panel
    input wire logic halted,
    input wire logic start_pulse,
    input wire logic load_button,
    input wire logic [3:0] reg_select,
    input wire logic fetch_active,
    input wire logic cache_enabled,
    input wire logic tape_loading_mode,
    input wire logic console_loading,
    input wire logic mreg_move,
    input wire logic proc_clear,
    // Micro-operation register moves
    input wire logic mem_stat_we,
    input wire logic proc_stat_we,
    input wire logic [3:0] wr_data,
    input wire logic summary_error_flag_we,
    input wire logic summary_error_flag_wd,
    // Memory subsystem
    input wire logic mem_micro_start,
    input wire logic mem_micro_done,
    input wire logic [3:0] access_stacks,
    input wire logic [3:0] memory_size_limit,
    input wire logic [3:0] installed_stacks,
    input wire logic mem_rd_valid,
    input wire logic [23:0] mem_rd_data,
    input wire logic err_rpt_valid,
    input wire mem_err_rpt_t err_rpt,
    input wire logic err_log_read,
    // Cache and micro fetch
    input wire logic cache_rd_valid,
    input wire logic hit_a,
    input wire logic hit_b,
    input wire logic [23:0] cache_data_a,
    input wire logic [23:0] cache_data_b,
    input wire key_entry_t key_a,
    input wire key_entry_t key_b,
    input wire logic micro_valid,
    input wire logic micro_parity_ok,
    input wire logic cassette_error,
    // Outputs
    output logic [3:0] port_condition_group,
    output logic [3:0] memory_error_status,
    output logic [3:0] processor_error_status,
    output logic summary_error_flag,
    output logic halt_request,
    output logic parity_lamp,
    output logic composite_int,
    output logic [23:0] mem_data_out,
    output logic [23:0] cache_data_out,
    output err_log_t err_log,
    output key_entry_t key_init,
    output logic mem_busy
);
    // Panel clear while halted at the clear column, or any start pulse
    logic clear_evt;
    assign clear_evt = start_pulse |
                       (halted & load_button & (reg_select == `CLEAR_COLUMN)); // RL3 RL12 RL20

    // Memory micro watchdog
    wd_state_t wd_q;
    logic [15:0] wd_cnt_q;
    logic timeout_evt;
    assign timeout_evt = (wd_q == WD_BUSY) & (wd_cnt_q == 16'(TIMEOUT_CYC - 1)) & ~mem_micro_done;
    assign mem_busy = (wd_q == WD_BUSY);

    // Watchdog counts busy cycles; a stuck micro stays busy after time-out
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wd_q <= WD_IDLE;
            wd_cnt_q <= 16'h0000;
        end else begin
            case (wd_q)
                WD_IDLE: begin
                    wd_cnt_q <= 16'h0000;
                    if (mem_micro_start) begin
                        wd_q <= WD_BUSY;
                    end
                end
                WD_BUSY: begin
                    if (mem_micro_done) begin
                        wd_q <= WD_IDLE;
                    end else if (wd_cnt_q != 16'(TIMEOUT_CYC - 1)) begin
                        wd_cnt_q <= wd_cnt_q + 16'h0001; // RL4
                    end
                end
                default: begin
                    wd_q <= WD_IDLE;
                end
            endcase
        end
    end

    // Out-of-bounds when access reaches beyond either size bound
    logic bounds_evt;
    logic [3:0] admin_size;
    assign admin_size = (memory_size_limit < installed_stacks) ? memory_size_limit :
                        installed_stacks;
    assign bounds_evt = mem_rd_valid & (access_stacks > admin_size); // RL5

    // Absent stacks return zeros with no correction
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mem_data_out <= 24'h000000;
        end else if (mem_rd_valid) begin
            mem_data_out <= bounds_evt ? 24'h000000 : mem_rd_data; // RL5
        end
    end

    // Error log priority
    logic [1:0] new_sev;
    logic [1:0] cur_sev;
    logic log_take;
    logic log_chg_evt;
    assign new_sev = err_rpt.cpu_ue ? `LOG_SEV_CPU : err_rpt.ncpu_ue ? `LOG_SEV_NCPU :
                     err_rpt.sbe ? `LOG_SEV_SBE : `LOG_SEV_NONE;
    assign cur_sev = err_log.cpu_ue ? `LOG_SEV_CPU : err_log.ncpu_ue ? `LOG_SEV_NCPU :
                     err_log.sbe ? `LOG_SEV_SBE : `LOG_SEV_NONE;
    // A same-cycle read empties the log first, so any report then lands in it
    assign log_take = err_rpt_valid & (new_sev != `LOG_SEV_NONE) &
                      (err_log_read | (new_sev > cur_sev)); // RL8
    assign log_chg_evt = err_rpt_valid & (new_sev != `LOG_SEV_NONE);

    // Log keeps first error unless a higher-ranked one arrives; a new report wins over a same-cycle read
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            err_log <= '0;
        end else if (log_take) begin
            err_log.board <= err_rpt.board; // RL9
            err_log.chip_row <= err_rpt.chip_row;
            err_log.syndrome <= err_rpt.syndrome;
            err_log.is_write <= err_rpt.is_write;
            err_log.multiple <= (cur_sev != `LOG_SEV_NONE) & ~err_log_read;
            err_log.sbe <= (err_log.sbe & ~err_log_read) | err_rpt.sbe;
            err_log.ncpu_ue <= (err_log.ncpu_ue & ~err_log_read) | err_rpt.ncpu_ue;
            err_log.cpu_ue <= err_rpt.cpu_ue;
        end else if (log_chg_evt & ~err_log_read) begin
            err_log.multiple <= 1'b1; // Equal or lower-ranked report lost
            err_log.sbe <= err_log.sbe | err_rpt.sbe;
            err_log.ncpu_ue <= err_log.ncpu_ue | err_rpt.ncpu_ue;
        end else if (err_log_read) begin
            err_log <= '0; // RL7
        end
    end

    // Memory error events
    logic cpu_ue_evt;
    logic [3:0] mem_set;
    assign cpu_ue_evt = err_rpt_valid & err_rpt.cpu_ue; // RL10
    assign mem_set = {timeout_evt, bounds_evt, log_chg_evt, cpu_ue_evt}; // RL4 RL7

    // Memory error status: set beats clear and write
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            memory_error_status <= 4'h0;
        end else if (clear_evt) begin
            memory_error_status <= mem_set; // RL3
        end else if (mem_stat_we) begin
            memory_error_status <= wr_data | mem_set; // RL11
        end else begin
            memory_error_status <= memory_error_status | mem_set; // RL22
        end
    end

    // Cache read: merge both blocks on a double hit
    logic dbl_evt;
    logic key_par_evt;
    assign dbl_evt = cache_rd_valid & hit_a & hit_b;
    assign key_par_evt = cache_rd_valid & (~(^key_a) | ~(^key_b)); // RL14

    // Cache data output
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cache_data_out <= 24'h000000;
        end else if (cache_rd_valid) begin
            cache_data_out <= (hit_a ? cache_data_a : 24'h000000) |
                              (hit_b ? cache_data_b : 24'h000000); // RL13
        end
    end

    // Initial key entry written into the key stores on a processor clear
    assign key_init = '{key: 8'h00, valid: 1'b1, parity: 1'b0}; // RL15

    // Processor error events
    logic mpar_evt;
    logic tape_evt;
    logic [3:0] proc_set;
    assign mpar_evt = micro_valid & ~micro_parity_ok & ~mreg_move & ~tape_loading_mode &
                      ~console_loading; // RL17
    assign tape_evt = cassette_error; // RL18
    assign proc_set = {dbl_evt, key_par_evt, mpar_evt, tape_evt}; // RL13

    // Processor error status: set beats clear and write
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            processor_error_status <= 4'h0;
        end else if (clear_evt) begin
            processor_error_status <= proc_set; // RL12
        end else if (proc_stat_we) begin
            processor_error_status <= wr_data | proc_set;
        end else begin
            processor_error_status <= processor_error_status | proc_set; // RL22
        end
    end

    // Any error event
    logic any_evt;
    assign any_evt = (|mem_set) | (|proc_set);

    // Summary flag: events set it, software may load it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            summary_error_flag <= 1'b0;
        end else if (any_evt) begin
            summary_error_flag <= 1'b1; // RL11
        end else if (summary_error_flag_we) begin
            summary_error_flag <= summary_error_flag_wd;
        end
    end

    // Lamp: lit by events only; a clear is beaten by a same-cycle event
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            parity_lamp <= 1'b0;
        end else if (any_evt) begin
            parity_lamp <= 1'b1; // RL19
        end else if (clear_evt) begin
            parity_lamp <= 1'b0; // RL20
        end
    end

    // Halt decision, combinational handshake to the sequencer
    logic fetch_en;
    assign fetch_en = fetch_active & cache_enabled;
    assign halt_request = timeout_evt | (bounds_evt & fetch_active) | // RL4 RL6
                          (cpu_ue_evt & fetch_active) | // RL10
                          (dbl_evt & fetch_en) | (key_par_evt & fetch_en) | // RL13 RL16
                          mpar_evt | // RL17
                          (processor_error_status[`PE_TAPE] & tape_loading_mode); // RL18

    // Port condition group mirror or strap
    always_comb begin
        if (port_present) begin
            port_condition_group = {port_missing, port_hipri, port_int, port_lockout}; // RL1
        end else begin
            port_condition_group = {strap_missing, 3'b000}; // RL2
        end
    end
    assign composite_int = port_condition_group[`PC_MISSING] |
                           port_condition_group[`PC_PORTINT] | other_int; // RL21

    // Unused input kept for clear sequencing by the key store owner
    logic unused_clear;
    assign unused_clear = proc_clear;

    // A time-out leaves its mark in the status and on the lamp
    a_timeout_sets: assert property (@(posedge clk) disable iff (!rst_b) // RL4
        timeout_evt |=> memory_error_status[`ME_TIMEOUT] && parity_lamp)
        else $error("time-out did not set status"); // RL4
    // The stuck micro must stop the machine in the same cycle
    a_timeout_halts: assert property (@(posedge clk) disable iff (!rst_b) // RL4
        timeout_evt |-> halt_request)
        else $error("time-out did not halt"); // RL4
    // Absent stacks read as zeros and flag the bound
    a_bounds_zero: assert property (@(posedge clk) disable iff (!rst_b) // RL5
        bounds_evt |=> mem_data_out == 24'h000000 && memory_error_status[`ME_BOUNDS])
        else $error("out-of-bounds data not zero"); // RL5
    // A quiet clear event empties the memory status and puts the lamp out
    a_mem_clear: assert property (@(posedge clk) disable iff (!rst_b) // RL3
        clear_evt && !any_evt |=> memory_error_status == 4'h0 && !parity_lamp)
        else $error("memory status not cleared"); // RL3
    // The same clear empties the processor status
    a_proc_clear: assert property (@(posedge clk) disable iff (!rst_b) // RL12
        clear_evt && !any_evt |=> processor_error_status == 4'h0)
        else $error("processor status not cleared"); // RL12
    // A latched bit survives cycles with no clear and no write
    a_status_hold: assert property (@(posedge clk) disable iff (!rst_b) // RL22
        memory_error_status[`ME_LOGCHG] && !clear_evt && !mem_stat_we |=>
        memory_error_status[`ME_LOGCHG])
        else $error("status bit dropped"); // RL22
    // Bad parity on key store A is flagged and summarised
    a_key_parity: assert property (@(posedge clk) disable iff (!rst_b) // RL14
        cache_rd_valid && !(^key_a) |=> processor_error_status[`PE_KEYPAR] && summary_error_flag)
        else $error("key parity not flagged"); // RL14
    // Tape loading carries no parity, so no micro parity error may appear
    a_mpar_suppress: assert property (@(posedge clk) disable iff (!rst_b) // RL17
        tape_loading_mode && !cache_rd_valid && !cassette_error && !proc_stat_we &&
        !clear_evt && !processor_error_status[`PE_MPAR] |=> !processor_error_status[`PE_MPAR])
        else $error("parity checked during tape load"); // RL17
    // With the cache off a double hit only flags, it never halts
    a_dbl_nohalt: assert property (@(posedge clk) disable iff (!rst_b) // RL13
        dbl_evt && !cache_enabled && !timeout_evt && !mpar_evt && !bounds_evt && !cpu_ue_evt &&
        !(processor_error_status[`PE_TAPE] && tape_loading_mode) |-> !halt_request)
        else $error("disabled cache double hit halted"); // RL13
    // Without the interchange the low bits are strapped false
    a_direct_conn: assert property (@(posedge clk) disable iff (!rst_b) // RL2
        !port_present |-> port_condition_group[2:0] == 3'b000)
        else $error("direct connect bits not false"); // RL2
    // Loading the summary flag by software must not light the lamp
    a_load_no_lamp: assert property (@(posedge clk) disable iff (!rst_b) // RL19
        summary_error_flag_we && !any_evt && !parity_lamp |=> !parity_lamp)
        else $error("software flag load lit the lamp");
endmodule : processor_error_status_regs

/* test/mem_far_end.sv */
// Far-end memory model: answers each memory micro start with a done pulse.
// Assumes the bench sets the answer delay; a delay of zero never answers.
`timescale 1ns/10ps
module mem_far_end (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [3:0] lat,
    output logic done
);
    logic [3:0] cnt_q; // Cycles left before done, zero when idle
    // Count down from a start; a zero delay models a stuck micro for the watchdog
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_q <= 4'h0;
            done <= 1'b0;
        end else begin
            done <= (cnt_q == 4'h1);
            if (start) begin
                cnt_q <= lat;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule : mem_far_end

/* test/processor_error_status_regs_tb.sv */
// Self-checking bench for the error status registers, halt and lamp.
// Assumes the far-end memory model answers micro starts; one clock domain.
`timescale 1ns/10ps
module processor_error_status_regs_tb
    import err_status_pkg::*;
;
    localparam int TO = 4; // Short watchdog count keeps the run brief
    localparam key_entry_t kgood = {8'h00, 1'b1, 1'b0}; // Odd parity entry
    logic clk, rst_b, port_present, port_missing, port_hipri, port_int, port_lockout;
    logic strap_missing, other_int, halted, start_pulse, load_button, fetch_active;
    logic cache_enabled, tape_loading_mode, console_loading, mreg_move, proc_clear;
    logic mem_stat_we, proc_stat_we, summary_error_flag_we, summary_error_flag_wd;
    logic mem_micro_start, mem_micro_done, mem_rd_valid, err_rpt_valid, err_log_read;
    logic cache_rd_valid, hit_a, hit_b, micro_valid, micro_parity_ok, cassette_error;
    logic [3:0] reg_select, wr_data, access_stacks, memory_size_limit, installed_stacks;
    logic [3:0] lat, port_condition_group, memory_error_status, processor_error_status;
    logic [23:0] mem_rd_data, cache_data_a, cache_data_b, mem_data_out, cache_data_out;
    logic summary_error_flag, halt_request, parity_lamp, composite_int, mem_busy, h;
    mem_err_rpt_t err_rpt;
    key_entry_t key_a, key_b, key_init;
    err_log_t err_log;
    int failures = 0;
    int samples_checked = 0;
    int i, n;
    // One ordinary case: event, fetch, cache enable, expected statuses and halt
    typedef struct packed {
        logic [2:0] ev;
        logic fa;
        logic ce;
        logic [3:0] em;
        logic [3:0] ep;
        logic h;
    } row_t;
    row_t rows [10] = '{
        '{3'h0, 1'b1, 1'b0, 4'h4, 4'h0, 1'b1}, '{3'h0, 1'b0, 1'b0, 4'h4, 4'h0, 1'b0},
        '{3'h1, 1'b0, 1'b0, 4'h2, 4'h0, 1'b0}, '{3'h2, 1'b1, 1'b0, 4'h3, 4'h0, 1'b1},
        '{3'h3, 1'b1, 1'b1, 4'h0, 4'h8, 1'b1}, '{3'h3, 1'b1, 1'b0, 4'h0, 4'h8, 1'b0},
        '{3'h4, 1'b1, 1'b1, 4'h0, 4'h4, 1'b1}, '{3'h7, 1'b1, 1'b0, 4'h0, 4'h4, 1'b0},
        '{3'h5, 1'b1, 1'b0, 4'h0, 4'h2, 1'b1}, '{3'h6, 1'b0, 1'b0, 4'h0, 4'h1, 1'b0}};

    processor_error_status_regs #(.TIMEOUT_CYC(TO)) uut (.clk, .rst_b, .port_present,
        .port_missing, .port_hipri, .port_int, .port_lockout, .strap_missing, .other_int,
        .halted, .start_pulse, .load_button, .reg_select, .fetch_active, .cache_enabled,
        .tape_loading_mode, .console_loading, .mreg_move, .proc_clear, .mem_stat_we,
        .proc_stat_we, .wr_data, .summary_error_flag_we, .summary_error_flag_wd,
        .mem_micro_start, .mem_micro_done, .access_stacks, .memory_size_limit,
        .installed_stacks, .mem_rd_valid, .mem_rd_data, .err_rpt_valid, .err_rpt,
        .err_log_read, .cache_rd_valid, .hit_a, .hit_b, .cache_data_a, .cache_data_b,
        .key_a, .key_b, .micro_valid, .micro_parity_ok, .cassette_error,
        .port_condition_group, .memory_error_status, .processor_error_status,
        .summary_error_flag, .halt_request, .parity_lamp, .composite_int, .mem_data_out,
        .cache_data_out, .err_log, .key_init, .mem_busy);
    mem_far_end mem (.clk(clk), .rst_b(rst_b), .start(mem_micro_start), .lat(lat),
        .done(mem_micro_done));

    // Free-running 25 MHz clock
    always #20 clk = ~clk;

    // Compare with four-state equality so unknowns never match
    task chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
        end
    endtask : chk
    // Move just past a rising edge, where every input change is made
    task step;
        @(posedge clk);
        #1;
    endtask : step
    // Raise one error event for a cycle, sampling the same-cycle halt
    task fire(input logic [2:0] ev, output logic hs);
        case (ev)
            3'h0: begin
                access_stacks = 4'h3; // Beyond the two-stack limit
                mem_micro_start = 1'b1;
                mem_rd_valid = 1'b1;
            end
            3'h1: err_rpt = {4'h1, 2'h0, 6'h01, 1'b0, 1'b1, 1'b0, 1'b0};
            3'h2: err_rpt = {4'h2, 2'h1, 6'h02, 1'b0, 1'b0, 1'b0, 1'b1};
            3'h3: {cache_rd_valid, hit_a, hit_b} = 3'h7;
            3'h4: key_a = {8'h00, 1'b1, 1'b1};
            3'h7: key_b = {8'h01, 1'b1, 1'b0};
            3'h5: {micro_valid, micro_parity_ok} = 2'h2;
            default: cassette_error = 1'b1;
        endcase
        err_rpt_valid = (ev == 3'h1 || ev == 3'h2);
        cache_rd_valid = cache_rd_valid | (ev == 3'h4) | (ev == 3'h7);
        @(negedge clk);
        hs = halt_request;
        step;
        {mem_micro_start, mem_rd_valid, err_rpt_valid, cache_rd_valid} = 4'h0;
        {micro_valid, micro_parity_ok, cassette_error, hit_a, hit_b} = 5'h08;
        key_a = kgood;
        key_b = kgood;
    endtask : fire
    // Start pulse and log read clear statuses, log and lamp; a flag reload and an in-bounds read ride along
    task clr;
        {start_pulse, err_log_read, summary_error_flag_we, mem_rd_valid} = 4'hf;
        access_stacks = 4'h1;
        step;
        {start_pulse, err_log_read, summary_error_flag_we, mem_rd_valid} = 4'h0;
        step;
        chk({memory_error_status, processor_error_status, parity_lamp}, 9'h0);
        chk({summary_error_flag, mem_data_out}, {1'b0, 24'h5a5a5a});
    endtask : clr
    // Send one report to the error log
    task send(input mem_err_rpt_t r);
        err_rpt = r;
        err_rpt_valid = 1'b1;
        step;
        err_rpt_valid = 1'b0;
        step;
    endtask : send
    // Print the counts and the verdict, then stop
    task end_sim;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    // Cuts a hang short well past the expected run of under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        end_sim;
    end

    // Main sequence: reset, table of cases, then the awkward cases
    initial begin
        {clk, rst_b, port_present, port_missing, port_hipri, port_int, port_lockout} = '0;
        {strap_missing, other_int, halted, start_pulse, load_button, fetch_active} = '0;
        {cache_enabled, tape_loading_mode, console_loading, mreg_move, proc_clear} = '0;
        {mem_stat_we, proc_stat_we, summary_error_flag_we, summary_error_flag_wd} = '0;
        {mem_rd_valid, err_rpt_valid, err_log_read, cache_rd_valid, hit_a, hit_b} = '0;
        {mem_micro_start, micro_valid, cassette_error, reg_select, wr_data} = '0;
        {err_rpt, mem_rd_data, cache_data_a, cache_data_b} = '0;
        {micro_parity_ok, key_a, key_b} = {1'b1, kgood, kgood};
        {access_stacks, memory_size_limit, installed_stacks, lat} = 16'h1241;
        repeat (10) step;
        rst_b = 1'b1;
        chk({memory_error_status, processor_error_status, parity_lamp, mem_busy}, 10'h0);
        chk(key_init, kgood);
        $display("test reset done");
        for (i = 0; i < 10; i++) begin
            {fetch_active, cache_enabled} = {rows[i].fa, rows[i].ce};
            {cache_data_a, cache_data_b, mem_rd_data} = {24'h0000f0, 24'h00000f, 24'h5a5a5a};
            fire(rows[i].ev, h);
            chk(h, rows[i].h);
            chk(memory_error_status, rows[i].em);
            chk(processor_error_status, rows[i].ep);
            chk({summary_error_flag, parity_lamp}, 2'h3);
            if (rows[i].ev == 3'h0) chk(mem_data_out, 24'h0);
            if (rows[i].ev == 3'h3) chk(cache_data_out, 24'h0000ff);
            repeat (3) step;
            chk({memory_error_status, processor_error_status}, {rows[i].em, rows[i].ep});
            clr;
        end
        {fetch_active, cache_enabled} = 2'h0;
        $display("test event table done");
        port_present = 1'b1;
        {port_missing, port_hipri, port_int, port_lockout} = 4'ha;
        step;
        chk({port_condition_group, composite_int}, 5'h15);
        {port_missing, port_hipri, port_int, port_lockout} = 4'h2;
        step;
        chk({port_condition_group, composite_int}, 5'h05);
        {port_present, strap_missing, other_int} = 3'h3;
        {port_missing, port_hipri, port_int, port_lockout} = 4'hf;
        step;
        chk({port_condition_group, composite_int}, 5'h11);
        {port_missing, port_hipri, port_int, port_lockout, strap_missing, other_int} = '0;
        $display("test port conditions done");
        {mem_stat_we, proc_stat_we, summary_error_flag_we, summary_error_flag_wd} = 4'hf;
        wr_data = 4'ha;
        step;
        {mem_stat_we, proc_stat_we, summary_error_flag_we, summary_error_flag_wd} = 4'h0;
        chk({memory_error_status, summary_error_flag, parity_lamp}, 6'h2a);
        fire(3'h6, h);
        chk({processor_error_status, parity_lamp}, 5'h17);
        for (i = 0; i < 3; i++) begin
            {halted, load_button} = {i != 0, 1'b1};
            reg_select = (i == 1) ? 4'h5 : 4'h6;
            step;
            load_button = 1'b0;
            step;
            n = (i == 2) ? 0 : 'h157;
            chk({memory_error_status, processor_error_status, parity_lamp}, n);
        end
        halted = 1'b0;
        $display("test writes and panel clear done");
        send({4'h3, 2'h2, 6'h15, 1'b0, 1'b0, 1'b1, 1'b0});
        chk({err_log, memory_error_status[1]}, {4'h3, 2'h2, 6'h15, 5'h02, 1'b1});
        send({4'h1, 2'h0, 6'h01, 1'b0, 1'b1, 1'b0, 1'b0});
        chk({err_log[16:5], err_log.multiple}, {4'h3, 2'h2, 6'h15, 1'b1});
        send({4'h9, 2'h1, 6'h2a, 1'b1, 1'b0, 1'b0, 1'b1});
        chk({err_log[16:4], err_log.cpu_ue}, {4'h9, 2'h1, 6'h2a, 1'b1, 1'b1});
        err_log_read = 1'b1;
        step;
        err_log_read = 1'b0;
        step;
        chk(err_log, '0);
        clr;
        $display("test error log done");
        for (i = 0; i < 3; i++) begin
            {mreg_move, tape_loading_mode, console_loading} = 3'h4 >> i;
            fire(3'h5, h);
            chk({h, processor_error_status}, 5'h0);
        end
        {mreg_move, tape_loading_mode, console_loading} = 3'h2;
        fire(3'h6, h);
        chk({halt_request, processor_error_status}, 5'h11);
        tape_loading_mode = 1'b0;
        step;
        chk(halt_request, 1'b0);
        clr;
        $display("test suppression and tape done");
        lat = 4'h0;
        mem_micro_start = 1'b1;
        step;
        mem_micro_start = 1'b0;
        for (n = 0; n < 20 && halt_request !== 1'b1; n++) @(negedge clk);
        chk(n, TO);
        step;
        chk({memory_error_status, summary_error_flag, parity_lamp, mem_busy}, 7'h47);
        lat = 4'h1;
        rst_b = 1'b0;
        repeat (10) step;
        rst_b = 1'b1;
        chk({memory_error_status, parity_lamp, mem_busy}, 6'h0);
        $display("test time-out done");
        end_sim;
    end
endmodule : processor_error_status_regs_tb
